// file: src/irq_ext_pkg.sv
`default_nettype none
package irq_ext_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses on the plain register port)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_SENSE_SELECT = 8'hF4;
    localparam logic [7:0] OFF_ENABLE = 8'hF5;
    localparam logic [7:0] OFF_STATUS_FLAGS = 8'hF6;
    localparam logic [7:0] OFF_PRIORITY_FIRST = 8'hF8;
    localparam logic [7:0] OFF_PRIORITY_SECOND = 8'hF9;
    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int NUM_SRC = 5;
    localparam logic [7:0] SRC_FIELD_MASK = 8'h1F;
    localparam logic [7:0] PRIO_SECOND_MASK = 8'hCA;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic SENSE_LEVEL = 1'b0;
    localparam logic SENSE_EDGE = 1'b1;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage
`default_nettype wire

// file: src/irq_ext_sense.sv
`timescale 1ns/100ps
`default_nettype none
module irq_ext_sense (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire irq_ext_pkg::reg_req_t reg_req,
    output logic [7:0] rdata,
    // external request pins, active low
    input wire logic [4:0] external_request_pin_b,
    // cpu exception logic
    input wire logic [4:0] exception_ack,
    output logic [4:0] irq_request,
    output logic [7:0] priority_first,
    output logic [7:0] priority_second
);
    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic [4:0] sync3_ff;
    logic [4:0] pin_low_ff;
    logic [4:0] nxt_pin_low;

    // pin level counts only once stages two and three agree
    always_comb begin
        nxt_pin_low = pin_low_ff;
        for (int i = 0; i < irq_ext_pkg::NUM_SRC; i++) begin
            if (sync2_ff[i] == sync3_ff[i]) begin
                nxt_pin_low[i] = ~sync3_ff[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff <= 5'h1F;
            sync2_ff <= 5'h1F;
            sync3_ff <= 5'h1F;
            pin_low_ff <= 5'h00;
        end else begin
            sync1_ff <= external_request_pin_b;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pin_low_ff <= nxt_pin_low;
        end
    end

    // falling pin edge: previous level high, new level low
    logic [4:0] fall_edge;
    assign fall_edge = nxt_pin_low & ~pin_low_ff;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [4:0] source_sense_select_ff;
    logic [4:0] source_enable_bit_ff;
    logic [7:0] prio_first_ff;
    logic [7:0] prio_second_ff;
    logic wr_sense;
    logic wr_enable;
    logic wr_flags;
    logic rd_flags;

    assign wr_sense = reg_req.wr && reg_req.addr == irq_ext_pkg::OFF_SENSE_SELECT;
    assign wr_enable = reg_req.wr && reg_req.addr == irq_ext_pkg::OFF_ENABLE;
    assign wr_flags = reg_req.wr && reg_req.addr == irq_ext_pkg::OFF_STATUS_FLAGS;
    assign rd_flags = reg_req.rd && reg_req.addr == irq_ext_pkg::OFF_STATUS_FLAGS;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            source_sense_select_ff <= 5'h00;
            source_enable_bit_ff <= 5'h00;
            prio_first_ff <= irq_ext_pkg::RESET_VALUE;
            prio_second_ff <= irq_ext_pkg::RESET_VALUE;
        end else begin
            if (wr_sense) begin
                source_sense_select_ff <= reg_req.wdata[4:0];
            end
            if (wr_enable) begin
                source_enable_bit_ff <= reg_req.wdata[4:0];
            end
            if (reg_req.wr && reg_req.addr == irq_ext_pkg::OFF_PRIORITY_FIRST) begin
                prio_first_ff <= reg_req.wdata;
            end
            if (reg_req.wr && reg_req.addr == irq_ext_pkg::OFF_PRIORITY_SECOND) begin
                prio_second_ff <= reg_req.wdata & irq_ext_pkg::PRIO_SECOND_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // request flags
    // ------------------------------------------------------------
    logic [4:0] source_request_flag_ff;
    logic [4:0] read_armed_ff;
    logic [4:0] flag_set;
    logic [4:0] flag_clr;
    logic [4:0] nxt_flag;

    always_comb begin
        for (int i = 0; i < irq_ext_pkg::NUM_SRC; i++) begin
            if (source_sense_select_ff[i] == irq_ext_pkg::SENSE_LEVEL) begin
                flag_set[i] = nxt_pin_low[i];
                flag_clr[i] = exception_ack[i] && !nxt_pin_low[i];
            end else begin
                flag_set[i] = fall_edge[i];
                flag_clr[i] = exception_ack[i];
            end
            // only a 0 after an armed read clears; a 1 is ignored
            if (wr_flags && read_armed_ff[i] && !reg_req.wdata[i]) begin
                flag_clr[i] = 1'b1;
            end
        end
        // a new event in the clearing cycle wins over the clear
        nxt_flag = flag_set | (source_request_flag_ff & ~flag_clr);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            source_request_flag_ff <= 5'h00;
        end else begin
            source_request_flag_ff <= nxt_flag;
        end
    end

    // a read while set arms the clear; the arm drops once the flag is gone
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            read_armed_ff <= 5'h00;
        end else begin
            for (int i = 0; i < irq_ext_pkg::NUM_SRC; i++) begin
                if (rd_flags && source_request_flag_ff[i]) begin
                    read_armed_ff[i] <= 1'b1;
                end else if (!nxt_flag[i]) begin
                    read_armed_ff[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // outputs and read data
    // ------------------------------------------------------------
    logic [7:0] nxt_rdata;

    always_comb begin
        case (reg_req.addr)
            irq_ext_pkg::OFF_SENSE_SELECT: nxt_rdata = {3'h0, source_sense_select_ff};
            irq_ext_pkg::OFF_ENABLE: nxt_rdata = {3'h0, source_enable_bit_ff};
            irq_ext_pkg::OFF_STATUS_FLAGS: nxt_rdata = {3'h0, source_request_flag_ff};
            irq_ext_pkg::OFF_PRIORITY_FIRST: nxt_rdata = prio_first_ff;
            irq_ext_pkg::OFF_PRIORITY_SECOND: nxt_rdata = prio_second_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else begin
            rdata <= reg_req.rd ? nxt_rdata : 8'h00;
        end
    end

    // registered so outputs come straight from flops; priorities lag one cycle, irq_request is built from nxt_flag so it does not lag the flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_request <= 5'h00;
            priority_first <= 8'h00;
            priority_second <= 8'h00;
        end else begin
            irq_request <= nxt_flag & source_enable_bit_ff;
            priority_first <= prio_first_ff;
            priority_second <= prio_second_ff;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // per-source terms; vector checks cover all five sources, not one sample bit
    logic [4:0] hold_flag;
    logic [4:0] ack_edge;
    logic [4:0] ack_level_low;
    logic [4:0] ack_level_high;
    logic [4:0] soft_clear;
    logic [4:0] edge_idle;
    logic [4:0] edge_hit;
    logic [4:0] level_low;

    assign hold_flag = source_request_flag_ff & ~read_armed_ff & ~exception_ack;
    assign ack_edge = source_sense_select_ff & exception_ack & ~fall_edge;
    assign ack_level_low = ~source_sense_select_ff & exception_ack & nxt_pin_low;
    assign ack_level_high = ~source_sense_select_ff & exception_ack & ~nxt_pin_low;
    assign soft_clear = {5{wr_flags}} & read_armed_ff & ~reg_req.wdata[4:0] & ~flag_set;
    assign edge_idle = source_sense_select_ff & ~source_request_flag_ff & ~fall_edge;
    assign edge_hit = source_sense_select_ff & fall_edge;
    assign level_low = ~source_sense_select_ff & nxt_pin_low;

    level_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!source_sense_select_ff[0] && nxt_pin_low[0]) |=> source_request_flag_ff[0])
        else $error("level source 0 low but flag not set");

    edge_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        (source_sense_select_ff[1] && fall_edge[1]) |=> source_request_flag_ff[1])
        else $error("edge on source 1 did not set flag");

    unarmed_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|hold_flag) |=> ((source_request_flag_ff & $past(hold_flag)) == $past(hold_flag)))
        else $error("flag cleared without prior read");

    level_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!source_sense_select_ff[0] && exception_ack[0] && !nxt_pin_low[0])
        |=> !source_request_flag_ff[0])
        else $error("level flag 0 not cleared by exception");

    edge_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|ack_edge) |=> ((source_request_flag_ff & $past(ack_edge)) == 5'h00))
        else $error("edge flag not cleared by exception");

    write_one_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_flags && reg_req.wdata[4] && !exception_ack[4] && !source_request_flag_ff[4]
        && !flag_set[4]) |=> !source_request_flag_ff[4])
        else $error("writing 1 set flag 4");

    request_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
        irq_request == $past(nxt_flag & source_enable_bit_ff))
        else $error("request does not follow flag and enable");

    prio_second_a: assert property (@(posedge clk) disable iff (!rst_b)
        (prio_second_ff & ~irq_ext_pkg::PRIO_SECOND_MASK) == 8'h00)
        else $error("unimplemented second priority bit set");

    // ------------------------------------------------------------
    // checks: pin sampling
    // ------------------------------------------------------------
    sync_agree_a: assert property (@(posedge clk) disable iff (!rst_b)
        ((pin_low_ff ^ $past(pin_low_ff)) & ($past(sync2_ff) ^ $past(sync3_ff))) == 5'h00)
        else $error("pin level taken before stages agreed");

    sync_high_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pin_low_ff & $past(sync2_ff) & $past(sync3_ff)) == 5'h00)
        else $error("pin seen low although both stages high");

    fall_held_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|fall_edge) |=> ((pin_low_ff & $past(fall_edge)) == $past(fall_edge)))
        else $error("falling edge not kept as low level");

    // ------------------------------------------------------------
    // checks: flag setting and clearing
    // ------------------------------------------------------------
    level_all_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|level_low) |=> ((source_request_flag_ff & $past(level_low)) == $past(level_low)))
        else $error("level source low but flag not set");

    edge_all_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|edge_hit) |=> ((source_request_flag_ff & $past(edge_hit)) == $past(edge_hit)))
        else $error("falling edge did not set flag");

    edge_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|edge_idle) |=> ((source_request_flag_ff & $past(edge_idle)) == 5'h00))
        else $error("edge flag set without a falling edge");

    flag_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
        (source_request_flag_ff & ~$past(source_request_flag_ff | flag_set)) == 5'h00)
        else $error("flag rose without a pin event");

    arm_by_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|(read_armed_ff & ~$past(read_armed_ff))) |-> $past(rd_flags))
        else $error("clear armed without a flag read");

    armed_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|soft_clear) |=> ((source_request_flag_ff & $past(soft_clear)) == 5'h00))
        else $error("armed zero write did not clear flag");

    level_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|ack_level_low)
        |=> ((source_request_flag_ff & $past(ack_level_low)) == $past(ack_level_low)))
        else $error("level flag cleared while pin still low");

    level_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (|ack_level_high) |=> ((source_request_flag_ff & $past(ack_level_high)) == 5'h00))
        else $error("level flag kept after exception with pin high");

    flag_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rd_flags) |-> (rdata == {3'h0, $past(source_request_flag_ff)}))
        else $error("flag read does not show the flags");

    // ------------------------------------------------------------
    // checks: control registers and outputs
    // ------------------------------------------------------------
    sense_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_sense |=> (source_sense_select_ff == $past(reg_req.wdata[4:0])))
        else $error("sense select write lost");

    enable_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_enable |=> (source_enable_bit_ff == $past(reg_req.wdata[4:0])))
        else $error("enable write lost");

    enable_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        ($past(reg_req.rd) && $past(reg_req.addr) == irq_ext_pkg::OFF_ENABLE)
        |-> (rdata == {3'h0, $past(source_enable_bit_ff)}))
        else $error("enable read does not show bits 4 to 0");

    enable_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
        (irq_request & ~$past(source_enable_bit_ff)) == 5'h00)
        else $error("request raised for a disabled source");

    prio_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_req.wr && reg_req.addr == irq_ext_pkg::OFF_PRIORITY_FIRST)
        |=> (prio_first_ff == $past(reg_req.wdata)))
        else $error("first priority write lost");

    prio_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_req.wr && reg_req.addr == irq_ext_pkg::OFF_PRIORITY_SECOND)
        |=> (prio_second_ff == ($past(reg_req.wdata) & irq_ext_pkg::PRIO_SECOND_MASK)))
        else $error("second priority write not masked");

    prio_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
        (priority_first == $past(prio_first_ff))
        && (priority_second == $past(prio_second_ff)))
        else $error("priority outputs do not follow registers");

    // no disable here: this one watches the reset itself, from its second edge
    reset_clear_a: assert property (@(posedge clk)
        (!rst_b && !$past(rst_b)) |-> (irq_request == 5'h00 && rdata == 8'h00
        && source_request_flag_ff == 5'h00 && source_enable_bit_ff == 5'h00
        && source_sense_select_ff == 5'h00 && read_armed_ff == 5'h00
        && prio_first_ff == 8'h00 && prio_second_ff == 8'h00))
        else $error("state not cleared during reset");
endmodule
`default_nettype wire

// file: dv/ext_devices.sv
`timescale 1ns/100ps
`default_nettype none
module ext_devices (
    // bench control
    input wire logic [4:0] hold_low,
    // active-low request pins
    output logic [4:0] pin_b
);
    // released pins are pulled up, so idle reads high
    assign pin_b = ~hold_low;
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk, rst_b;
    irq_ext_pkg::reg_req_t req;
    logic [7:0] rdata, prio_a, prio_b;
    logic [4:0] pins_b, hold_low, ack, irq;
    int failures, total_checks, cycles;
    irq_ext_sense dut (.clk(clk), .rst_b(rst_b), .reg_req(req), .rdata(rdata),
        .external_request_pin_b(pins_b), .exception_ack(ack), .irq_request(irq),
        .priority_first(prio_a), .priority_second(prio_b));
    ext_devices devs (.hold_low(hold_low), .pin_b(pins_b));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ------------------------------------------------------------
    // bus and pin helpers
    // ------------------------------------------------------------
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
    endtask
    // sync takes 3-4 cycles, 6 leaves margin
    task automatic pin(logic [4:0] v);
        @(posedge clk);
        hold_low <= v;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic ackp(logic [4:0] v);
        @(posedge clk);
        ack <= v;
        @(posedge clk);
        ack <= 5'h00;
    endtask
    task automatic irq_is(logic [4:0] exp);
        @(posedge clk);
        #1;
        chk("irq_request", {3'h0, exp}, {3'h0, irq});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] offs [5];
        offs = '{8'hF4, 8'hF5, 8'hF6, 8'hF8, 8'hF9};
        foreach (offs[i]) rd(offs[i], 8'h00);
        rd(8'h10, 8'h00);
        chk("priority_first", 8'h00, prio_a);
        $display("test reset done");
    endtask
    task automatic t_regs;
        wr(8'hF4, 8'hFF);
        wr(8'hF5, 8'hFF);
        wr(8'hF8, 8'hFF);
        wr(8'hF9, 8'hFF);
        wr(8'h10, 8'h55);
        rd(8'hF4, 8'h1F);
        rd(8'hF5, 8'h1F);
        rd(8'hF8, 8'hFF);
        rd(8'hF9, 8'hCA);
        rd(8'h10, 8'h00);
        chk("priority_first", 8'hFF, prio_a);
        chk("priority_second", 8'hCA, prio_b);
        $display("test registers done");
    endtask
    task automatic t_edge;
        wr(8'hF4, 8'h02);
        wr(8'hF5, 8'h02);
        pin(5'h02);
        pin(5'h00);
        irq_is(5'h02);
        wr(8'hF6, 8'h00);
        wr(8'hF6, 8'hFF);
        rd(8'hF6, 8'h02);
        wr(8'hF6, 8'h00);
        rd(8'hF6, 8'h00);
        pin(5'h02);
        pin(5'h00);
        rd(8'hF6, 8'h02);
        ackp(5'h02);
        rd(8'hF6, 8'h00);
        $display("test edge done");
    endtask
    task automatic t_level;
        wr(8'hF4, 8'h00);
        wr(8'hF5, 8'h00);
        pin(5'h01);
        rd(8'hF6, 8'h01);
        irq_is(5'h00);
        wr(8'hF5, 8'h01);
        irq_is(5'h01);
        ackp(5'h01);
        rd(8'hF6, 8'h01);
        pin(5'h00);
        ackp(5'h01);
        rd(8'hF6, 8'h00);
        irq_is(5'h00);
        $display("test level done");
    endtask
    task automatic t_rst;
        wr(8'hF5, 8'h1F);
        pin(5'h10);
        irq_is(5'h10);
        rd(8'hF6, 8'h10);
        @(posedge clk);
        rst_b <= 1'b0;
        hold_low <= 5'h00;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'hF5, 8'h00);
        rd(8'hF6, 8'h00);
        irq_is(5'h00);
        $display("test mid-run reset done");
    endtask
    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // whole run needs well under 1000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        rst_b = 1'b0;
        req = '0;
        hold_low = 5'h00;
        ack = 5'h00;
        failures = 0;
        total_checks = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_regs();
        t_edge();
        t_level();
        t_rst();
        wrap_up();
    end
endmodule
`default_nettype wire
